// file: hdl/storage_pkg.sv
// Package for the sector storage controller: register offsets, status bits, commands and timing.
// Assumes one 100 MHz clock and a doubleword register port from the processor core.
`default_nettype none
package storage_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [5:0] OFF_STATUS_SETUP = 6'h00;
    localparam logic [5:0] OFF_FIRST_SECTOR = 6'h08;
    localparam logic [5:0] OFF_SECTOR_TOTAL = 6'h10;
    localparam logic [5:0] OFF_BUFFER_ADDR = 6'h18;
    localparam logic [5:0] OFF_OP_COMMAND = 6'h20;
    // ------------------------------------------------------------------
    // Fields and codes
    // ------------------------------------------------------------------
    localparam int BIT_BUSY = 0;
    localparam int BIT_ERROR = 1;
    localparam int BIT_IRQ_EN = 0;
    localparam int ADDR_W = 44;
    localparam logic [63:0] CMD_READ = 64'h0;
    localparam logic [63:0] CMD_WRITE = 64'h1;
    localparam int IRQ_SOURCE = 1;
    localparam int IRQ_SOURCES = 64;
    localparam int WORD_BYTES = 8;
    // ------------------------------------------------------------------
    // Defaults and timing
    // ------------------------------------------------------------------
    localparam int SECTOR_SIZE_DEF = 512;
    localparam int CAPACITY_DEF = 2000;
    localparam int LATENCY_DEF = 10000;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_MOVE = 2'b01,
        ST_WAIT = 2'b10
    } op_state_t;
endpackage : storage_pkg
`default_nettype wire

// file: hdl/word_skid.sv
// Two-entry buffer with valid and ready on both sides for doubleword data.
// Assumes a single clock and a synchronous active-high reset.
`default_nettype none
module word_skid
#(
    parameter int W = 64
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] mem_q [2];
    logic rd_q;
    logic wr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // Ready stays honest: only free slots are offered.
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage and pointers.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop)
            begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    cover_full_c: cover property (@(posedge clk) disable iff (rst) cnt_q == 2'h2);
endmodule : word_skid
`default_nettype wire

// file: hdl/sector_storage_controller.sv
// Sector storage controller: register page, sector copy engine and completion interrupt.
// Assumes a storage port and a memory port with valid/ready handshakes on the same clock.
`default_nettype none
module sector_storage_controller
    import storage_pkg::*;
#(
    parameter int SECTOR_SIZE = SECTOR_SIZE_DEF,
    parameter int CAPACITY = CAPACITY_DEF,
    parameter int LATENCY = LATENCY_DEF
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [63:0] REG_WDATA,
    output logic [63:0] REG_RDATA,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic [63:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [63:0] MEM_RDATA,
    output logic STO_REQ,
    output logic STO_WE,
    output logic [63:0] STO_INDEX,
    output logic [63:0] STO_WDATA,
    input wire logic STO_ACK,
    input wire logic [63:0] STO_RDATA,
    output logic [IRQ_SOURCES-1:0] IRQ_LINES
);
    // ------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------
    localparam int WORDS_PER_SECTOR = SECTOR_SIZE / WORD_BYTES;

    logic irq_en_q;
    logic [63:0] first_q;
    logic [63:0] total_q;
    logic [ADDR_W-1:0] addr_q;
    logic dir_q;
    logic busy_q;
    logic error_q;
    logic fail_q;
    logic irq_q;
    op_state_t state_q;
    logic [63:0] words_left_q;
    logic [63:0] src_idx_q;
    logic [63:0] dst_idx_q;
    logic [31:0] lat_q;
    logic cmd_wr;
    logic accept;
    logic bad_req;
    logic [64:0] end_sector;
    logic [63:0] src_data;
    logic src_valid;
    logic src_ready;
    logic [63:0] snk_data;
    logic snk_valid;
    logic snk_ready;
    logic src_pending_q;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    assign cmd_wr = REG_WR && (REG_ADDR == OFF_OP_COMMAND);
    assign accept = cmd_wr && !busy_q;

    // Setup keeps only the enable bit; other bits are discarded.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            irq_en_q <= 1'b0;
        else if (REG_WR && REG_ADDR == OFF_STATUS_SETUP)
            irq_en_q <= REG_WDATA[BIT_IRQ_EN];
    end

    // Parameters hold until rewritten; writes have no side effects.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            first_q <= 64'h0;
            total_q <= 64'h0;
            addr_q <= '0;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == OFF_FIRST_SECTOR)
                first_q <= REG_WDATA;
            if (REG_ADDR == OFF_SECTOR_TOTAL)
                total_q <= REG_WDATA;
            if (REG_ADDR == OFF_BUFFER_ADDR)
                addr_q <= {REG_WDATA[ADDR_W-1:3], 3'h0};
        end
    end

    // Status read: busy and error in the low bits, zeros elsewhere.
    always_comb
    begin
        REG_RDATA = 64'h0;
        if (REG_RD && REG_ADDR == OFF_STATUS_SETUP)
        begin
            REG_RDATA[BIT_BUSY] = busy_q;
            REG_RDATA[BIT_ERROR] = error_q;
        end
    end

    // ------------------------------------------------------------------
    // Request checking
    // ------------------------------------------------------------------
    // The end is computed one bit wider so a huge count cannot wrap into range.
    assign end_sector = {1'b0, first_q} + {1'b0, total_q};
    assign bad_req = (total_q == 64'h0)
        || (end_sector > 65'(CAPACITY)) || (total_q > 64'(CAPACITY));

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Errors skip the copy but still wait the latency, so no operation completes before the latency has passed.
    // The verdict waits in fail_q so the error bit keeps showing the last finished operation.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            error_q <= 1'b0;
            fail_q <= 1'b0;
            dir_q <= 1'b0;
            lat_q <= 32'h0;
            words_left_q <= 64'h0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        busy_q <= 1'b1;
                        dir_q <= (REG_WDATA == CMD_WRITE);
                        lat_q <= 32'(LATENCY);
                        words_left_q <= 64'(total_q * 64'(WORDS_PER_SECTOR));
                        fail_q <= bad_req;
                        state_q <= bad_req ? ST_WAIT : ST_MOVE;
                    end
                end
                ST_MOVE:
                begin
                    if (lat_q != 32'h0)
                        lat_q <= lat_q - 32'h1;
                    if (snk_valid && snk_ready && words_left_q == 64'h1)
                        state_q <= ST_WAIT;
                    if (snk_valid && snk_ready)
                        words_left_q <= words_left_q - 64'h1;
                end
                ST_WAIT:
                begin
                    if (lat_q > 32'h1)
                        lat_q <= lat_q - 32'h1;
                    else
                    begin
                        lat_q <= 32'h0;
                        error_q <= fail_q;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Data path: source read, buffer, sink write
    // ------------------------------------------------------------------
    // Read side fetches one word at a time and offers it to the buffer.
    assign MEM_REQ = (state_q == ST_MOVE) && (dir_q ? (!src_pending_q && src_idx_q != words_left_q + dst_idx_q)
        : snk_valid);
    assign STO_REQ = (state_q == ST_MOVE) && (!dir_q ? (!src_pending_q && src_idx_q != words_left_q + dst_idx_q)
        : snk_valid);
    assign MEM_WE = !dir_q;
    assign STO_WE = dir_q;
    assign MEM_ADDR = dir_q ? ADDR_W'(addr_q + ADDR_W'(src_idx_q << 3))
        : ADDR_W'(addr_q + ADDR_W'(dst_idx_q << 3));
    assign STO_INDEX = (dir_q ? dst_idx_q : src_idx_q) + first_q * 64'(WORDS_PER_SECTOR);
    assign MEM_WDATA = snk_data;
    assign STO_WDATA = snk_data;
    assign src_valid = src_pending_q;
    assign snk_ready = dir_q ? STO_ACK : MEM_ACK;

    // Captured source word is held until the buffer takes it.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || accept)
        begin
            src_pending_q <= 1'b0;
            src_idx_q <= 64'h0;
            src_data <= 64'h0;
        end
        else if (src_pending_q)
        begin
            if (src_ready)
                src_pending_q <= 1'b0;
        end
        else if ((dir_q ? MEM_REQ && MEM_ACK : STO_REQ && STO_ACK))
        begin
            src_pending_q <= 1'b1;
            src_data <= dir_q ? MEM_RDATA : STO_RDATA;
            src_idx_q <= src_idx_q + 64'h1;
        end
    end

    // Destination index advances on each accepted write.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || accept)
            dst_idx_q <= 64'h0;
        else if (snk_valid && snk_ready && state_q == ST_MOVE)
            dst_idx_q <= dst_idx_q + 64'h1;
    end

    word_skid #(.W(64)) buf_u
    (
        .clk(CLK),
        .rst(SYS_RST || accept),
        .in_data(src_data),
        .in_valid(src_valid),
        .in_ready(src_ready),
        .out_data(snk_data),
        .out_valid(snk_valid),
        .out_ready(snk_ready && state_q == ST_MOVE)
    );

    // ------------------------------------------------------------------
    // Completion interrupt
    // ------------------------------------------------------------------
    // One pulse per completion keeps the router count exact.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            irq_q <= 1'b0;
        else
            irq_q <= irq_en_q && state_q == ST_WAIT && lat_q <= 32'h1;
    end

    always_comb
    begin
        IRQ_LINES = '0;
        IRQ_LINES[IRQ_SOURCE] = irq_q;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    busy_on_accept_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        accept |=> busy_q) else $error("busy not set on accepted command");
    drop_while_busy_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (cmd_wr && busy_q) |=> $stable(dir_q)) else $error("busy command disturbed transfer");
    zero_count_err_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (accept && total_q == 64'h0) |=> fail_q && state_q == ST_WAIT) else $error("zero count not error");
    range_err_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (accept && end_sector > 65'(CAPACITY)) |=> fail_q) else $error("range not error");
    error_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (busy_q ##1 busy_q) |-> $stable(error_q)) else $error("error bit changed before completion");
    status_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        REG_RDATA[63:2] == 62'h0) else $error("status high bits set");
    irq_gated_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        irq_q |-> $past(irq_en_q) && !busy_q) else $error("interrupt without enable or completion");
    no_early_done_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        accept |=> busy_q [*8]) else $error("completion too early");
    status_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!busy_q && !cmd_wr) |=> $stable(error_q) && !busy_q) else $error("status changed without command");
    irq_single_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        irq_q |=> !irq_q) else $error("interrupt longer than one pulse");

    cover_read_c: cover property (@(posedge CLK) accept && REG_WDATA == CMD_READ && !bad_req);
    cover_write_c: cover property (@(posedge CLK) accept && REG_WDATA == CMD_WRITE && !bad_req);
    cover_err_c: cover property (@(posedge CLK) accept && bad_req);
    cover_irq_c: cover property (@(posedge CLK) irq_q);
endmodule : sector_storage_controller
`default_nettype wire

// file: dv/sector_far_side.sv
// Far-side model of one controller port (memory or storage): 64 doublewords.
// Assumes a request holds until the one-cycle acknowledge, and that the controller
// does not request during reset.
`default_nettype none
module sector_far_side
(
    input wire logic clk,
    input wire logic req,
    input wire logic we,
    input wire logic [5:0] idx,
    input wire logic [63:0] wdata,
    output logic ack,
    output logic [63:0] rdata,
    input wire logic [3:0] stall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] cells [0:63];
    int wait_n;
    int ops;
    initial
    begin
        ack = 1'b0;
        rdata = 64'h0;
        wait_n = 0;
        ops = 0;
    end
    // Answer after the chosen stall. Outside the answer cycle the data toggles, so a late sample shows.
    always @(posedge clk)
    begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req === 1'b1 && ack !== 1'b1)
        begin
            if (wait_n < int'(stall))
                wait_n <= wait_n + 1;
            else
            begin
                wait_n <= 0;
                ack <= 1'b1;
                ops <= ops + 1;
                rdata <= cells[idx];
                if (we === 1'b1)
                    cells[idx] <= wdata;
            end
        end
    end
endmodule : sector_far_side
`default_nettype wire

// file: dv/sector_storage_controller_test.sv
// Testbench for the sector storage controller: register tasks and copy scenarios.
// Assumes the package, the design and the far-side model are compiled first.
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module sector_storage_controller_test
    import storage_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Small geometry keeps the run short: two words per sector, eight sectors.
    localparam int SECT = 16;
    localparam int CAP = 8;
    localparam int LAT = 20;
    logic clk, rst, reg_wr, reg_rd, mem_req, mem_we, mem_ack, sto_req, sto_we, sto_ack;
    logic [5:0] reg_addr;
    logic [63:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, sto_index, sto_wdata, sto_rdata, irq_lines, s;
    logic [ADDR_W-1:0] mem_addr;
    logic [3:0] stall;
    int errors = 0;
    int checked = 0;
    int irq_cnt = 0;
    int stray = 0;
    int ops0;
    logic last_err = 1'b0;
    sector_storage_controller #(.SECTOR_SIZE(SECT), .CAPACITY(CAP), .LATENCY(LAT)) DUT (
        .CLK(clk), .SYS_RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .MEM_REQ(mem_req), .MEM_WE(mem_we),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
        .STO_REQ(sto_req), .STO_WE(sto_we), .STO_INDEX(sto_index), .STO_WDATA(sto_wdata),
        .STO_ACK(sto_ack), .STO_RDATA(sto_rdata), .IRQ_LINES(irq_lines));
    // Memory is indexed by doubleword, so the low three byte-address bits are not used.
    sector_far_side mem_side (.clk(clk), .req(mem_req), .we(mem_we), .idx(mem_addr[8:3]),
        .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata), .stall(stall));
    sector_far_side sto_side (.clk(clk), .req(sto_req), .we(sto_we), .idx(sto_index[5:0]),
        .wdata(sto_wdata), .ack(sto_ack), .rdata(sto_rdata), .stall(stall));
    // Clock of 10 ns.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count completion pulses on the router line and anything on the other lines.
    always @(posedge clk)
    begin
        if (irq_lines[IRQ_SOURCE] === 1'b1)
            irq_cnt++;
        if ((irq_lines & ~(64'h1 << IRQ_SOURCE)) !== 64'h0)
            stray++;
    end
    // ------------------------------------------------------------------
    // Register access tasks
    // ------------------------------------------------------------------
    // One store: strobe high for exactly one rising edge.
    task automatic wr(input logic [5:0] a, input logic [63:0] d);
        @(negedge clk);
        reg_rd = 1'b0;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    // One load: the answer is combinational, so it is sampled once settled after the falling edge.
    task automatic rd(input logic [5:0] a, output logic [63:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        #1 d = reg_rdata;
    endtask : rd
    // Issue a command, try a second one while busy, wait for completion and check status.
    task automatic run(input logic [63:0] code, input logic exp_err, input int exp_irq);
        int n;
        int irq0;
        logic [63:0] st;
        irq0 = irq_cnt;
        wr(OFF_OP_COMMAND, code);
        rd(OFF_STATUS_SETUP, st);
        `CHK("busy after command", 1'b1, st[BIT_BUSY])
        `CHK("error held while busy", last_err, st[BIT_ERROR])
        wr(OFF_OP_COMMAND, code ^ 64'h1);
        n = 3;
        while (st[BIT_BUSY] === 1'b1 && n < 3000)
        begin
            rd(OFF_STATUS_SETUP, st);
            n++;
        end
        `CHK("cycles until done", 1'b1, n >= LAT)
        `CHK("status after done", {62'h0, exp_err, 1'b0}, st)
        repeat (2) @(negedge clk);
        `CHK("completion pulses", exp_irq, irq_cnt - irq0)
        repeat (10) @(negedge clk);
        rd(OFF_STATUS_SETUP, st);
        `CHK("status held", {62'h0, exp_err, 1'b0}, st)
        last_err = exp_err;
    endtask : run
    // Print the counts and the verdict, then stop.
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 64'h0;
        stall = 4'h0;
        for (int i = 0; i < 64; i++)
        begin
            mem_side.cells[i] = 64'hA000 + i;
            sto_side.cells[i] = 64'hB000 + i;
        end
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(OFF_STATUS_SETUP, s);
        `CHK("status after reset", 64'h0, s)
        rd(6'h28, s);
        `CHK("unmapped load", 64'h0, s)
        // Parameters in a scrambled order; none of these stores may raise anything.
        wr(OFF_STATUS_SETUP, 64'hFFFF_FFFF_FFFF_FFFF);
        wr(OFF_BUFFER_ADDR, 64'h40);
        wr(OFF_SECTOR_TOTAL, 64'h2);
        wr(OFF_FIRST_SECTOR, 64'h1);
        rd(OFF_STATUS_SETUP, s);
        `CHK("status after setup", 64'h0, s)
        `CHK("pulses from setup", 0, irq_cnt)
        run(CMD_READ, 1'b0, 1);
        for (int k = 0; k < 5; k++)
            `CHK("memory word", (k < 4 ? 64'hB002 + k : 64'hA00C), mem_side.cells[8 + k])
        // Last two sectors with a slow far side; the count register keeps its old value.
        stall = 4'h3;
        wr(OFF_FIRST_SECTOR, 64'h6);
        wr(OFF_BUFFER_ADDR, 64'h80);
        run(CMD_WRITE, 1'b0, 1);
        for (int k = 0; k < 5; k++)
            `CHK("storage word", (k < 4 ? 64'hA010 + k : 64'hB010), sto_side.cells[12 + k])
        // Requests past the end and of zero sectors must fail and move nothing.
        ops0 = mem_side.ops + sto_side.ops;
        wr(OFF_FIRST_SECTOR, 64'h7);
        run(CMD_READ, 1'b1, 1);
        wr(OFF_SECTOR_TOTAL, 64'h0);
        wr(OFF_FIRST_SECTOR, 64'h0);
        run(CMD_WRITE, 1'b1, 1);
        `CHK("words moved on error", ops0, mem_side.ops + sto_side.ops)
        // Interrupt off (only bit 0 counts), then a good command clears the error.
        wr(OFF_STATUS_SETUP, 64'h2);
        wr(OFF_SECTOR_TOTAL, 64'h1);
        run(CMD_READ, 1'b0, 0);
        `CHK("other router lines", 0, stray)
        end_of_test();
    end
    // Watchdog: the scenarios need well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule : sector_storage_controller_test
`default_nettype wire
